/* File: src/fvc_top.sv */
// Fault value capture: twelve trigger-capture channels and eight real-time slots.
// Assumes stage start/trip levels and measurements are synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module fvc_top #(
  parameter int CH = fvc_pkg::CHANNELS,
  parameter int RT = fvc_pkg::RT_SLOTS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Stage signals indexed by source code; index 0 is unused
  input wire logic [fvc_pkg::NUM_SRC-1:0] stage_start_i,
  input wire logic [fvc_pkg::NUM_SRC-1:0] stage_trip_i,
  // Measurement fed to each source (phase max or residual), signed hundredths
  input wire logic [fvc_pkg::NUM_SRC-1:0][fvc_pkg::VAL_W-1:0] stage_value_i,
  input wire logic [CH-1:0][fvc_pkg::SRC_W-1:0] ch_source_i,
  input wire logic [CH-1:0][1:0] ch_trigger_i,
  input wire logic [3:0] local_rd_addr_i,
  input wire logic [3:0] proto_rd_addr_i,
  input wire logic proto_active_i,
  input wire logic [fvc_pkg::NUM_MEAS-1:0][fvc_pkg::VAL_W-1:0] meas_i,
  input wire logic [RT-1:0][fvc_pkg::MEAS_W-1:0] rt_select_i,
  input wire logic [RT-1:0] rt_enable_i,
  input wire logic rt_per_unit_i,
  input wire logic [fvc_pkg::VAL_W-1:0] pu_gain_i,
  output logic [fvc_pkg::VAL_W-1:0] local_rd_data_o,
  output logic [fvc_pkg::VAL_W-1:0] proto_rd_data_o,
  output logic proto_rd_valid_o,
  output logic [CH-1:0] ch_captured_o,
  output logic [RT-1:0][fvc_pkg::VAL_W-1:0] rt_value_o,
  output logic [RT-1:0] rt_valid_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FVC_RD_LOCAL = 2'b01,
    FVC_RD_PROTO = 2'b10
  } fvc_rd_t;

  typedef struct packed {
    logic [CH-1:0] trig_prev;
    logic [CH-1:0] captured;
    logic [CH-1:0][fvc_pkg::VAL_W-1:0] val;
    fvc_rd_t rd_phase;
    logic [fvc_pkg::VAL_W-1:0] local_data;
    logic [fvc_pkg::VAL_W-1:0] proto_data;
    logic proto_valid;
    logic [RT-1:0][fvc_pkg::VAL_W-1:0] rt_val;
    logic [RT-1:0] rt_vld;
  } fvc_st_t;

  fvc_st_t s_r;
  fvc_st_t s_nxt;
  fvc_store_if st ();
  logic [CH-1:0] trig_now;
  logic [CH-1:0] trig_rise;

  // ----------------------------------------------------------------
  // Trigger decode per channel
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      logic [fvc_pkg::SRC_W-1:0] src;
      logic in_range;
      assign src = ch_source_i[g];
      // Unused and out-of-range codes never trigger
      assign in_range = (src != fvc_pkg::SRC_UNUSED) && (src <= fvc_pkg::SRC_LAST);
      always_comb begin
        trig_now[g] = 1'b0;
        if (in_range) begin
          unique case (ch_trigger_i[g])
            fvc_pkg::FVC_TRIG_TRIP: trig_now[g] = stage_trip_i[src];
            fvc_pkg::FVC_TRIG_START: trig_now[g] = stage_start_i[src];
            fvc_pkg::FVC_TRIG_EITHER: trig_now[g] = stage_start_i[src] | stage_trip_i[src];
            default: trig_now[g] = stage_trip_i[src];
          endcase
        end
      end
      assign trig_rise[g] = trig_now[g] & ~s_r.trig_prev[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [2*fvc_pkg::VAL_W-1:0] prod;
    logic [fvc_pkg::MEAS_W-1:0] sel;
    prod = '0;
    sel = '0;
    s_nxt = s_r;
    s_nxt.trig_prev = trig_now;
    // Lowest channel with a fresh edge goes to the store this cycle; a
    // mirror copy in val keeps every channel's value without waiting
    st.wr_en = 1'b0;
    st.wr_addr = '0;
    st.wr_data = fvc_pkg::VAL_ZERO;
    for (int c = CH - 1; c >= 0; c--) begin
      if (trig_rise[c]) begin
        // Value present at the edge, held until the next qualifying edge
        s_nxt.val[c] = stage_value_i[ch_source_i[c]];
        s_nxt.captured[c] = 1'b1;
        st.wr_en = 1'b1;
        st.wr_addr = 4'(c);
        st.wr_data = stage_value_i[ch_source_i[c]];
      end
    end
    // Store read port alternates between the local menu and the protocol
    unique case (s_r.rd_phase)
      FVC_RD_LOCAL: begin
        st.rd_addr = local_rd_addr_i;
        s_nxt.rd_phase = FVC_RD_PROTO;
      end
      FVC_RD_PROTO: begin
        st.rd_addr = proto_rd_addr_i;
        s_nxt.rd_phase = FVC_RD_LOCAL;
      end
      default: begin
        st.rd_addr = local_rd_addr_i;
        s_nxt.rd_phase = FVC_RD_LOCAL;
      end
    endcase
    // Direct views from the mirror so neither reader sees the alternation
    s_nxt.local_data = (32'(local_rd_addr_i) < CH) ? s_r.val[local_rd_addr_i]
                                                   : fvc_pkg::VAL_ZERO;
    s_nxt.proto_data = (proto_active_i && 32'(proto_rd_addr_i) < CH)
                       ? s_r.val[proto_rd_addr_i] : fvc_pkg::VAL_ZERO;
    s_nxt.proto_valid = proto_active_i;
    // Real-time slots: selection over the whole measurement index space
    for (int r = 0; r < RT; r++) begin
      sel = rt_select_i[r];
      if (rt_enable_i[r] && 32'(sel) < fvc_pkg::NUM_MEAS) begin
        if (rt_per_unit_i) begin
          prod = $signed(meas_i[sel]) * $signed({1'b0, pu_gain_i[fvc_pkg::VAL_W-2:0]});
          s_nxt.rt_val[r] = fvc_pkg::VAL_W'(prod >>> fvc_pkg::PU_SHIFT);
        end else begin
          s_nxt.rt_val[r] = meas_i[sel];
        end
        s_nxt.rt_vld[r] = 1'b1;
      end else begin
        s_nxt.rt_val[r] = fvc_pkg::VAL_ZERO;
        s_nxt.rt_vld[r] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.rd_phase <= FVC_RD_LOCAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Value store
  // ----------------------------------------------------------------
  fvc_store #(.DEPTH(CH)) u_store (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .st(st)
  );

  assign local_rd_data_o = s_r.local_data;
  assign proto_rd_data_o = s_r.proto_data;
  assign proto_rd_valid_o = s_r.proto_valid;
  assign ch_captured_o = s_r.captured;
  assign rt_value_o = s_r.rt_val;
  assign rt_valid_o = s_r.rt_vld;
endmodule
`default_nettype wire

/* File: src/fvc_pkg.sv */
// Package for the fault value capture block: source, trigger and measurement codes.
// Assumes measurement values arrive as signed hundredths from the measurement datapath.
package fvc_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CHANNELS = 12;
  localparam int RT_SLOTS = 8;
  localparam int VAL_W = 32;
  localparam int SRC_W = 5;
  localparam int MEAS_W = 7;
  localparam int NUM_SRC = 18;
  localparam int NUM_MEAS = 80;

  // ----------------------------------------------------------------
  // Source codes: 0 unused, then stages of each protection function
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_UNUSED = 5'h00;
  localparam logic [4:0] SRC_OC_FIRST = 5'h01;
  localparam logic [4:0] SRC_DOC_FIRST = 5'h04;
  localparam logic [4:0] SRC_EF_FIRST = 5'h08;
  localparam logic [4:0] SRC_DEF_FIRST = 5'h0C;
  localparam logic [4:0] SRC_LOCATOR = 5'h10;
  localparam logic [4:0] SRC_LAST = 5'h10;

  // ----------------------------------------------------------------
  // Trigger codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FVC_TRIG_TRIP = 2'h0,
    FVC_TRIG_START = 2'h1,
    FVC_TRIG_EITHER = 2'h2
  } fvc_trig_t;

  // ----------------------------------------------------------------
  // Measurement index layout: 5 inputs x (ff, trms, 11 harmonics) = 65,
  // then sequence, calculated residual and angles
  // ----------------------------------------------------------------
  localparam int MEAS_FF_BASE = 0;
  localparam int MEAS_TRMS_BASE = 5;
  localparam int MEAS_HARM_BASE = 10;
  localparam int MEAS_SEQ_BASE = 65;
  localparam int MEAS_CALC = 68;
  localparam int MEAS_ANG_BASE = 69;

  // Per-unit scale: value * pu_gain[30:0] / 2^PU_SHIFT (top bit of pu_gain ignored)
  localparam int PU_SHIFT = 16;
  localparam logic [VAL_W-1:0] VAL_ZERO = 32'h0000_0000;
endpackage

/* File: src/fvc_if.sv */
// Carrier between the capture top and its value store.
// Assumes one clock domain; write and read both sit on clock_i.
`timescale 1ns/1ps
`default_nettype none
interface fvc_store_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [fvc_pkg::VAL_W-1:0] wr_data;
  logic [3:0] rd_addr;
  logic [fvc_pkg::VAL_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: src/fvc_store.sv */
// Storage for captured channel values, one word per channel.
// Assumes at most one write per cycle; read data come from a register.
`timescale 1ns/1ps
`default_nettype none
module fvc_store #(
  parameter int DEPTH = fvc_pkg::CHANNELS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  fvc_store_if.mem st
);
  typedef struct packed {
    logic [DEPTH-1:0][fvc_pkg::VAL_W-1:0] mem;
    logic [fvc_pkg::VAL_W-1:0] rd;
  } fvc_store_st_t;
  fvc_store_st_t s_r;
  fvc_store_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (st.wr_en) begin
      s_nxt.mem[st.wr_addr] = st.wr_data;
    end
    s_nxt.rd = (32'(st.rd_addr) < DEPTH) ? s_r.mem[st.rd_addr] : fvc_pkg::VAL_ZERO;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign st.rd_data = s_r.rd;
endmodule
`default_nettype wire

/* File: testbench/fvc_sva.sv */
// Port checker for the fault value capture top.
// Assumes a bind onto fvc_top; everything runs on clock_i.
`timescale 1ns/1ps
`default_nettype none
module fvc_sva #(parameter int CH = 12, parameter int RT = 8) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [fvc_pkg::NUM_SRC-1:0] stage_trip_i,
  input wire logic [CH-1:0][fvc_pkg::SRC_W-1:0] ch_source_i,
  input wire logic [CH-1:0][1:0] ch_trigger_i,
  input wire logic [3:0] local_rd_addr_i,
  input wire logic proto_active_i,
  input wire logic [fvc_pkg::NUM_MEAS-1:0][fvc_pkg::VAL_W-1:0] meas_i,
  input wire logic [RT-1:0][fvc_pkg::MEAS_W-1:0] rt_select_i,
  input wire logic [RT-1:0] rt_enable_i,
  input wire logic rt_per_unit_i,
  input wire logic [fvc_pkg::VAL_W-1:0] local_rd_data_o,
  input wire logic [fvc_pkg::VAL_W-1:0] proto_rd_data_o,
  input wire logic proto_rd_valid_o,
  input wire logic [CH-1:0] ch_captured_o,
  input wire logic [RT-1:0][fvc_pkg::VAL_W-1:0] rt_value_o
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_proto_gated: assert property (!$past(proto_active_i) |-> proto_rd_data_o == 32'h0)
    else $error("protocol data while inactive");
  a_valid_follows: assert property (!$past(sys_rst_i) |-> proto_rd_valid_o == $past(proto_active_i))
    else $error("protocol valid wrong");
  a_unused_refused: assert property ($rose(ch_captured_o[0]) |-> $past(ch_source_i[0]) inside {[5'h01:5'h10]})
    else $error("capture from unused source");
  a_captured_sticky: assert property (!$past(sys_rst_i) |-> (ch_captured_o & $past(ch_captured_o)) == $past(ch_captured_o))
    else $error("captured flag fell");
  a_trip_capture: assert property (ch_source_i[0] == 5'h01 && ch_trigger_i[0] == 2'h0 && $rose(stage_trip_i[1]) |=> ch_captured_o[0])
    else $error("trip edge not captured");
  a_value_hold: assert property ((local_rd_addr_i == 4'h0 && ch_source_i[0] == 5'h01 && ch_trigger_i[0] == 2'h0 && !stage_trip_i[1]) [*4] |-> $stable(local_rd_data_o))
    else $error("held value changed");
  a_oob_zero: assert property (local_rd_addr_i > 4'hB |=> local_rd_data_o == 32'h0)
    else $error("read past last channel not zero");
  a_rt_primary: assert property (rt_enable_i[0] && !rt_per_unit_i |=> rt_value_o[0] == $past(meas_i[rt_select_i[0]]))
    else $error("primary slot value wrong");
endmodule
bind fvc_top fvc_sva #(.CH(CH), .RT(RT)) chk (.*);
`default_nettype wire

/* File: testbench/fvc_stage_model.sv */
// Model of the protection stages feeding the capture block.
// Assumes hit() is called from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module fvc_stage_model (
  input wire logic clock_i,
  output logic [17:0] stage_start_o,
  output logic [17:0] stage_trip_o,
  output logic [17:0][31:0] stage_value_o
);
  initial begin
    stage_start_o = '0;
    stage_trip_o = '0;
    stage_value_o = '0;
  end
  // Level stands two edges; value drifts after release so a late capture shows
  task automatic hit(input logic [4:0] s, input logic trip, input logic [31:0] v);
    @(posedge clock_i);
    stage_value_o[s] <= v;
    if (trip) stage_trip_o[s] <= 1'b1;
    else stage_start_o[s] <= 1'b1;
    repeat (2) @(posedge clock_i);
    stage_trip_o[s] <= 1'b0;
    stage_start_o[s] <= 1'b0;
    stage_value_o[s] <= ~v;
  endtask
endmodule
`default_nettype wire

/* File: testbench/fvc_top_test.sv */
// Self-checking bench for the fault value capture top.
// Assumes the stage model drives start, trip and value levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module fvc_top_test;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [17:0] stage_start_i;
  logic [17:0] stage_trip_i;
  logic [17:0][31:0] stage_value_i;
  logic [11:0][4:0] ch_source_i = {5'h00, 5'h11, 5'h03, 5'h0D, 5'h09, 5'h05,
    5'h02, 5'h10, 5'h0C, 5'h08, 5'h04, 5'h01};
  logic [11:0][1:0] ch_trigger_i = 24'h924924;
  logic [3:0] local_rd_addr_i = 4'h0;
  logic [3:0] proto_rd_addr_i = 4'h0;
  logic proto_active_i = 1'b1;
  logic [79:0][31:0] meas_i = '0;
  logic [7:0][6:0] rt_select_i = '0;
  logic [7:0] rt_enable_i = 8'h00;
  logic rt_per_unit_i = 1'b0;
  logic [31:0] pu_gain_i = 32'h0;
  logic [31:0] local_rd_data_o, proto_rd_data_o;
  logic proto_rd_valid_o;
  logic [11:0] ch_captured_o;
  logic [7:0][31:0] rt_value_o;
  logic [7:0] rt_valid_o;
  int err_count = 0;
  int n_compared = 0;
  fvc_stage_model stg (.clock_i(clock_i), .stage_start_o(stage_start_i),
    .stage_trip_o(stage_trip_i), .stage_value_o(stage_value_i));
  fvc_top dut (.*);
  initial forever #5 clock_i = ~clock_i;
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic report_and_stop;
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [3:0] ch, input logic [31:0] e);
    @(posedge clock_i);
    local_rd_addr_i <= ch;
    proto_rd_addr_i <= ch;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("local value", e, local_rd_data_o)
    `CHK("proto value", e, proto_rd_data_o)
  endtask
  // Start then trip on each source: start mode keeps the first, others the last
  task automatic s_capture;
    logic [31:0] e;
    for (int i = 0; i < 12; i++) begin
      stg.hit(ch_source_i[i], 1'b0, 32'hF000_0000 | 32'(i));
      stg.hit(ch_source_i[i], 1'b1, 32'h0001_0000 | 32'(i));
    end
    for (int i = 0; i < 13; i++) begin
      e = (i % 3 == 1) ? 32'hF000_0000 | 32'(i) : 32'h0001_0000 | 32'(i);
      rd(4'(i), (i < 10) ? e : 32'h0);
    end
    `CHK("captured", 12'h3FF, ch_captured_o)
  endtask
  task automatic s_proto;
    @(posedge clock_i);
    proto_active_i <= 1'b0;
    proto_rd_addr_i <= 4'h0;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("proto gated", 32'h0, proto_rd_data_o)
    `CHK("proto valid", 1'b0, proto_rd_valid_o)
    proto_active_i <= 1'b1;
  endtask
  task automatic s_rt(input logic pu, input logic [7:0] en);
    @(posedge clock_i);
    for (int k = 0; k < 8; k++) begin
      rt_select_i[k] <= 7'(k * 10 + 9);
      meas_i[k * 10 + 9] <= 32'h0000_1000 * 32'(k + 1);
    end
    rt_enable_i <= en;
    rt_per_unit_i <= pu;
    pu_gain_i <= 32'h0000_8000;
    repeat (2) @(posedge clock_i);
    #1;
    for (int k = 0; k < 8; k++)
      if (en[k]) `CHK("rt value", (32'h0000_1000 >> pu) * 32'(k + 1), rt_value_o[k])
    `CHK("rt valid", en, rt_valid_o)
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    `CHK("captured idle", 12'h000, ch_captured_o)
    s_capture();
    s_proto();
    s_rt(1'b0, 8'hFF);
    s_rt(1'b1, 8'h5A);
    report_and_stop();
  end
endmodule
`default_nettype wire
